// ---- rtl/alt_lookup_table.sv ----
// Operation
// - Sixteen entries, each a 32-bit tag plus four state bits.
// - Lookup compares all entries; 9-bit result at bits 11:3, rest zero.
// - Result: state at 11:8, hit at 7, entry index at 6:3.
// - Miss: hit zero, state 0000, index is least recently used entry.
// - Hit: hit one, matching index, that entry's state bits.
// - Load or hitting lookup makes entry most recent; miss changes nothing.
// - Load stores source as tag and immediate as state of entry.
// - State write changes state only; tag and ordering untouched.
// - Optional pointer load: bits 5:0 zero, 9:6 index, 11:10 constant.
// - Pointer update delay equals a local control register write delay.
// - Pointer value becomes usable three instructions after the operation.
// - Tag read returns tag; state read returns state at 11:8; no reorder.
// - Table contents and ordering survive engine reset untouched.
// - Clear zeroes all tags and states; order entry 0 to 15.
// - State bits carry no meaning; only stored and returned.
`timescale 1ns/100ps
`default_nettype none
module alt_lookup_table
    import alt_pkg::*;
#(
    parameter int PTR_DELAY = ALT_PTR_DELAY_INSTR
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // Operation request, one per cycle
    input wire logic i_op_valid,
    input wire logic [2:0] i_op_code,
    input wire logic [ALT_IDX_W-1:0] i_entry,
    input wire logic [ALT_DATA_W-1:0] i_source,
    input wire logic [ALT_STATE_W-1:0] i_state_imm,
    input wire logic i_ptr_load_en,
    input wire logic [ALT_PTR_CONST_W-1:0] i_ptr_const,
    // Instruction retire strobe, counts pointer delay
    input wire logic i_instr_step,
    // Result
    output logic o_result_valid,
    output logic [ALT_DATA_W-1:0] o_result,
    // Local memory pointer
    output logic [ALT_PTR_W-1:0] o_local_mem_pointer
);
    // Elaboration check: delays 1 to 7 only, though the three-bit counter would also serve 8
    if (PTR_DELAY < 1 || PTR_DELAY > 7) begin : g_bad_delay
        $error("alt_lookup_table: PTR_DELAY out of range 1..7");
    end

    // ------------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------------
    alt_op_t op;
    logic do_lookup;
    logic do_load;
    logic do_wr_state;
    logic do_rd_tag;
    logic do_rd_state;
    logic do_clear;
    logic [ALT_ENTRIES-1:0] match;
    logic hit;
    logic [ALT_IDX_W-1:0] hit_idx;
    logic [ALT_IDX_W-1:0] lru_idx;
    logic [ALT_TAG_W-1:0] rd_tag;
    logic [ALT_STATE_W-1:0] rd_state;
    logic [ALT_IDX_W-1:0] rd_idx;

    assign op = alt_op_t'(i_op_code);
    assign do_lookup = i_op_valid && (op == ALT_OP_LOOKUP);
    assign do_load = i_op_valid && (op == ALT_OP_LOAD);
    assign do_wr_state = i_op_valid && (op == ALT_OP_WR_STATE);
    assign do_rd_tag = i_op_valid && (op == ALT_OP_RD_TAG);
    assign do_rd_state = i_op_valid && (op == ALT_OP_RD_STATE);
    assign do_clear = i_op_valid && (op == ALT_OP_CLEAR);

    // ------------------------------------------------------------------
    // Storage and ordering
    // ------------------------------------------------------------------
    alt_lru_if lru_bus ();

    alt_tag_store #(
        .ENTRIES(ALT_ENTRIES)
    ) u_store (
        .i_clk_sys(i_clk_sys),
        .i_wr_tag(do_load),
        .i_wr_state(do_load || do_wr_state),
        .i_clear(do_clear),
        .i_wr_idx(i_entry),
        .i_wr_tag_val(i_source),
        .i_wr_state_val(i_state_imm),
        .i_key(i_source),
        .o_match(match),
        .i_rd_idx(rd_idx),
        .o_rd_tag(rd_tag),
        .o_rd_state(rd_state)
    );

    alt_lru_order u_order (
        .i_clk_sys(i_clk_sys),
        .lru(lru_bus)
    );

    // Hit encoder; duplicates are excluded by program discipline
    always_comb begin
        hit_idx = '0;
        for (int i = ALT_ENTRIES - 1; i >= 0; i--) begin
            if (match[i]) begin
                hit_idx = ALT_IDX_W'(i);
            end
        end
    end
    assign hit = |match;
    assign lru_idx = lru_bus.lru_idx;

    // Ordering moves on load, hit or clear only, never on reads or misses
    assign lru_bus.init = do_clear;
    assign lru_bus.touch = do_load || (do_lookup && hit);
    assign lru_bus.touch_idx = do_load ? i_entry : hit_idx;

    // ------------------------------------------------------------------
    // Lookup result, captured in the request cycle
    // ------------------------------------------------------------------
    logic [8:0] lookup_word;
    logic [ALT_STATE_W-1:0] hit_state;
    logic [ALT_DATA_W-1:0] lk_result;
    logic [ALT_DATA_W-1:0] next_lk_result;
    logic [1:0] rsel;
    logic [1:0] next_rsel;
    logic rvalid;
    logic next_rvalid;

    // State of the hit entry comes through the registered read port
    // a cycle later, so the state field is merged at the output stage
    assign hit_state = rd_state;

    always_comb begin
        lookup_word = {ALT_STATE_CLEAR, 1'b0, lru_idx};
        if (hit) begin
            lookup_word = {ALT_STATE_CLEAR, 1'b1, hit_idx};
        end
        next_lk_result = '0;
        next_lk_result[ALT_RES_STATE_LSB +: 1] = '0;
        next_lk_result[ALT_RES_HIT_BIT] = lookup_word[4];
        next_lk_result[ALT_RES_IDX_LSB +: ALT_IDX_W] =
            lookup_word[ALT_IDX_W-1:0];
        next_rvalid = do_lookup || do_rd_tag || do_rd_state;
        next_rsel = 2'h0;
        if (do_rd_tag) begin
            next_rsel = 2'h1;
        end else if (do_rd_state) begin
            next_rsel = 2'h2;
        end
        if (!i_reset_n) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        lk_result <= next_lk_result;
        rsel <= next_rsel;
        rvalid <= next_rvalid;
    end

    // The store reads the addressed entry; for a lookup hit the read
    // index must be the hit entry, so a lookup retargets the read port.
    // On a miss the read data are ignored and the state field stays zero
    assign rd_idx = do_lookup ? hit_idx : i_entry;

    // Output assembly
    always_comb begin
        o_result = '0;
        case (rsel)
            2'h1: begin
                o_result = rd_tag;
            end
            2'h2: begin
                o_result[ALT_RES_STATE_LSB +: ALT_STATE_W] = rd_state;
            end
            default: begin
                o_result = lk_result;
                if (lk_result[ALT_RES_HIT_BIT]) begin
                    o_result[ALT_RES_STATE_LSB +: ALT_STATE_W] =
                        hit_state;
                end
            end
        endcase
    end
    assign o_result_valid = rvalid;

    // ------------------------------------------------------------------
    // Local memory pointer with control-register write latency
    // ------------------------------------------------------------------
    logic [ALT_PTR_W-1:0] ptr;
    logic [ALT_PTR_W-1:0] next_ptr;
    logic [ALT_PTR_W-1:0] pend_val;
    logic [ALT_PTR_W-1:0] next_pend_val;
    logic [2:0] pend_cnt;
    logic [2:0] next_pend_cnt;
    logic pend;
    logic next_pend;
    logic [ALT_PTR_W-1:0] new_ptr;

    // Low six bits forced zero; two lowest are read-only
    always_comb begin
        new_ptr = '0;
        new_ptr[ALT_PTR_IDX_LSB +: ALT_IDX_W] =
            hit ? hit_idx : lru_idx;
        new_ptr[ALT_PTR_CONST_LSB +: ALT_PTR_CONST_W] = i_ptr_const;
    end

    // Same staging as a local control register write: usable after
    // PTR_DELAY retired instructions
    always_comb begin
        next_ptr = ptr;
        next_pend_val = pend_val;
        next_pend_cnt = pend_cnt;
        next_pend = pend;
        if (pend && i_instr_step) begin
            if (pend_cnt == 3'(PTR_DELAY - 1)) begin
                next_ptr = pend_val;
                next_pend = 1'b0;
            end else begin
                next_pend_cnt = pend_cnt + 3'h1;
            end
        end
        if (do_lookup && i_ptr_load_en) begin
            next_pend_val = new_ptr;
            next_pend_cnt = 3'h0;
            next_pend = 1'b1;
        end
        if (!i_reset_n) begin
            next_ptr = ALT_PTR_RESET;
            next_pend = 1'b0;
            next_pend_cnt = 3'h0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        ptr <= next_ptr;
        pend_val <= next_pend_val;
        pend_cnt <= next_pend_cnt;
        pend <= next_pend;
    end
    assign o_local_mem_pointer = ptr;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_miss_zero_state: assert property (@(posedge i_clk_sys)
        disable iff (!i_reset_n)
        (do_lookup && !hit) |=> (o_result[11:7] == 5'h00 &&
        o_result[31:12] == '0 && o_result[2:0] == 3'h0))
        else $error("miss result not clean");
    a_hit_index: assert property (@(posedge i_clk_sys)
        disable iff (!i_reset_n)
        (do_lookup && hit) |=> (o_result[7] &&
        o_result[6:3] == $past(hit_idx)))
        else $error("hit index wrong");
    a_miss_keeps_lru: assert property (@(posedge i_clk_sys)
        disable iff (!i_reset_n)
        (do_lookup && !hit) |=> $stable(lru_idx))
        else $error("miss changed ordering");
    a_clear_order: assert property (@(posedge i_clk_sys)
        disable iff (!i_reset_n)
        do_clear |=> (lru_idx == 4'h0))
        else $error("clear ordering wrong");
    a_load_readback: assert property (@(posedge i_clk_sys)
        disable iff (!i_reset_n)
        do_load ##1 (i_op_valid && op == ALT_OP_RD_TAG &&
        i_entry == $past(i_entry)) |=> (o_result == $past(i_source, 2)))
        else $error("load tag not stored");
    a_state_read_fmt: assert property (@(posedge i_clk_sys)
        disable iff (!i_reset_n)
        do_rd_state |=> (o_result[31:12] == '0 && o_result[7:0] == 8'h00))
        else $error("state read not clean");
    a_ptr_low_zero: assert property (@(posedge i_clk_sys)
        disable iff (!i_reset_n)
        o_local_mem_pointer[5:0] == 6'h00)
        else $error("pointer low bits set");
    a_ptr_delay: assert property (@(posedge i_clk_sys)
        disable iff (!i_reset_n)
        (do_lookup && i_ptr_load_en) |=> $stable(o_local_mem_pointer))
        else $error("pointer updated too early");
    a_wr_state_lru: assert property (@(posedge i_clk_sys)
        disable iff (!i_reset_n)
        do_wr_state |=> $stable(lru_idx))
        else $error("state write changed ordering");
    a_read_keeps_lru: assert property (@(posedge i_clk_sys)
        disable iff (!i_reset_n)
        (do_rd_tag || do_rd_state) |=> $stable(lru_idx))
        else $error("read changed ordering");
    a_clear_tag_zero: assert property (@(posedge i_clk_sys)
        disable iff (!i_reset_n)
        do_clear ##1 do_rd_tag |=> (o_result == 32'h00000000))
        else $error("clear left a tag set");
    a_result_valid: assert property (@(posedge i_clk_sys)
        disable iff (!i_reset_n)
        (do_lookup || do_rd_tag || do_rd_state) |=> o_result_valid)
        else $error("result valid missing");
    a_ptr_needs_step: assert property (@(posedge i_clk_sys)
        disable iff (!i_reset_n)
        !i_instr_step |=> $stable(o_local_mem_pointer))
        else $error("pointer moved without a step");
endmodule : alt_lookup_table
`default_nettype wire

// ---- rtl/alt_lru_order.sv ----
`timescale 1ns/100ps
`default_nettype none
// Time-ordered list: slot 0 holds the least recently used entry
module alt_lru_order
    import alt_pkg::*;
(
    // Clock
    input wire logic i_clk_sys,
    // Control
    alt_lru_if.order_end lru
);
    logic [ALT_IDX_W-1:0] order [ALT_ENTRIES];
    logic [ALT_IDX_W-1:0] next_order [ALT_ENTRIES];
    logic [ALT_ENTRIES-1:0] at_or_above;

    // ------------------------------------------------------------------
    // Position match: slots at and above the touched entry shift down
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < ALT_ENTRIES; g++) begin : g_pos
            if (g == 0) begin : g_first
                assign at_or_above[g] = (order[g] == lru.touch_idx);
            end else begin : g_rest
                assign at_or_above[g] = at_or_above[g-1] |
                    (order[g] == lru.touch_idx);
            end
        end
    endgenerate

    // Next ordering
    always_comb begin
        for (int i = 0; i < ALT_ENTRIES; i++) begin
            next_order[i] = order[i];
            if (lru.init) begin
                next_order[i] = ALT_IDX_W'(i);
            end else if (lru.touch && at_or_above[i]) begin
                if (i == ALT_ENTRIES - 1) begin
                    next_order[i] = lru.touch_idx;
                end else begin
                    next_order[i] = order[i+1];
                end
            end
        end
    end

    // No reset: contents survive engine reset
    always_ff @(posedge i_clk_sys) begin
        order <= next_order;
    end

    assign lru.lru_idx = order[0];
endmodule : alt_lru_order
`default_nettype wire

// ---- rtl/alt_tag_store.sv ----
`timescale 1ns/100ps
`default_nettype none
// Tag and state storage with registered read port and parallel match
module alt_tag_store
    import alt_pkg::*;
#(
    parameter int ENTRIES = ALT_ENTRIES
) (
    // Clock
    input wire logic i_clk_sys,
    // Write and clear
    input wire logic i_wr_tag,
    input wire logic i_wr_state,
    input wire logic i_clear,
    input wire logic [ALT_IDX_W-1:0] i_wr_idx,
    input wire logic [ALT_TAG_W-1:0] i_wr_tag_val,
    input wire logic [ALT_STATE_W-1:0] i_wr_state_val,
    // Match
    input wire logic [ALT_TAG_W-1:0] i_key,
    output logic [ENTRIES-1:0] o_match,
    // Read
    input wire logic [ALT_IDX_W-1:0] i_rd_idx,
    output logic [ALT_TAG_W-1:0] o_rd_tag,
    output logic [ALT_STATE_W-1:0] o_rd_state
);
    // Elaboration check: every index value must name a real entry
    if (ENTRIES != (1 << ALT_IDX_W)) begin : g_bad_entries
        $error("alt_tag_store: ENTRIES must match index width");
    end

    logic [ALT_TAG_W-1:0] tags [ENTRIES];
    logic [ALT_STATE_W-1:0] states [ENTRIES];
    logic [ALT_TAG_W-1:0] next_tags [ENTRIES];
    logic [ALT_STATE_W-1:0] next_states [ENTRIES];
    logic [ALT_TAG_W-1:0] next_rd_tag;
    logic [ALT_STATE_W-1:0] next_rd_state;

    // Full 32-bit equality on every entry at once
    genvar g;
    generate
        for (g = 0; g < ENTRIES; g++) begin : g_cmp
            assign o_match[g] = (tags[g] == i_key);
        end
    endgenerate

    // Next contents
    always_comb begin
        for (int i = 0; i < ENTRIES; i++) begin
            next_tags[i] = tags[i];
            next_states[i] = states[i];
            if (i_clear) begin
                next_tags[i] = ALT_CLEAR_TAG;
                next_states[i] = ALT_STATE_CLEAR;
            end else if (i_wr_idx == ALT_IDX_W'(i)) begin
                if (i_wr_tag) begin
                    next_tags[i] = i_wr_tag_val;
                end
                if (i_wr_state) begin
                    next_states[i] = i_wr_state_val;
                end
            end
        end
        next_rd_tag = tags[i_rd_idx];
        next_rd_state = states[i_rd_idx];
    end

    // Storage is never reset, so an engine reset keeps the table
    always_ff @(posedge i_clk_sys) begin
        tags <= next_tags;
        states <= next_states;
        o_rd_tag <= next_rd_tag;
        o_rd_state <= next_rd_state;
    end
endmodule : alt_tag_store
`default_nettype wire

// ---- shared/alt_lru_if.sv ----
`timescale 1ns/100ps
`default_nettype none
// Usage ordering control between the table and its ordering module
interface alt_lru_if;
    import alt_pkg::*;
    logic touch;
    logic [ALT_IDX_W-1:0] touch_idx;
    logic init;
    logic [ALT_IDX_W-1:0] lru_idx;
    modport table_end (output touch, output touch_idx, output init,
        input lru_idx);
    modport order_end (input touch, input touch_idx, input init,
        output lru_idx);
endinterface : alt_lru_if
`default_nettype wire

// ---- shared/alt_pkg.sv ----
package alt_pkg;
    // ------------------------------------------------------------------
    // Table geometry
    // ------------------------------------------------------------------
    localparam int ALT_ENTRIES = 16;
    localparam int ALT_IDX_W = 4;
    localparam int ALT_TAG_W = 32;
    localparam int ALT_STATE_W = 4;
    localparam int ALT_DATA_W = 32;
    localparam int ALT_PTR_W = 12;

    // ------------------------------------------------------------------
    // Result and pointer field positions
    // ------------------------------------------------------------------
    localparam int ALT_RES_IDX_LSB = 3;
    localparam int ALT_RES_HIT_BIT = 7;
    localparam int ALT_RES_STATE_LSB = 8;
    localparam int ALT_PTR_IDX_LSB = 6;
    localparam int ALT_PTR_CONST_LSB = 10;
    localparam int ALT_PTR_CONST_W = 2;

    // ------------------------------------------------------------------
    // Values and timing
    // ------------------------------------------------------------------
    localparam logic [31:0] ALT_CLEAR_TAG = 32'h00000000;
    localparam logic [3:0] ALT_STATE_CLEAR = 4'h0;
    localparam logic [11:0] ALT_PTR_RESET = 12'h000;
    localparam int ALT_PTR_DELAY_INSTR = 3;

    // Operation codes from the issuing pipeline
    typedef enum logic [2:0] {
        ALT_OP_NONE,
        ALT_OP_LOOKUP,
        ALT_OP_LOAD,
        ALT_OP_WR_STATE,
        ALT_OP_RD_TAG,
        ALT_OP_RD_STATE,
        ALT_OP_CLEAR
    } alt_op_t;
endpackage : alt_pkg

// ---- tb/alt_issue_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// Issuing pipeline stand-in: one operation a cycle, driven 1 ns late
module alt_issue_model
    import alt_pkg::*;
(
    // Clock
    input wire logic i_clk_sys,
    // Operation out
    output logic o_op_valid,
    output logic [2:0] o_op_code,
    output logic [ALT_IDX_W-1:0] o_entry,
    output logic [ALT_DATA_W-1:0] o_source,
    output logic [ALT_STATE_W-1:0] o_state_imm,
    output logic o_ptr_load_en,
    output logic [ALT_PTR_CONST_W-1:0] o_ptr_const,
    output logic o_instr_step,
    // Answer in
    input wire logic i_result_valid,
    input wire logic [ALT_DATA_W-1:0] i_result
);
    // Quiet pipeline at time zero
    initial begin
        o_op_valid = 1'b0;
        o_op_code = 3'h0;
        o_entry = 4'h0;
        o_source = 32'h0;
        o_state_imm = 4'h0;
        o_ptr_load_en = 1'b0;
        o_ptr_const = 2'h0;
        o_instr_step = 1'b0;
    end

    // One instruction; answer read once the taking edge has settled
    task automatic issue(input alt_op_t op, input logic [3:0] ent,
        input logic [31:0] src, input logic [3:0] st, input logic pen,
        input logic [1:0] pc, output logic v, output logic [31:0] r);
        o_op_valid = 1'b1;
        o_op_code = op;
        o_entry = ent;
        o_source = src;
        o_state_imm = st;
        o_ptr_load_en = pen;
        o_ptr_const = pc;
        o_instr_step = 1'b1;
        @(posedge i_clk_sys);
        #1;
        v = i_result_valid;
        r = i_result;
    endtask : issue

    // Idle cycles; released key flips so a stale value never matches
    task automatic idle(input int n, input logic step);
        repeat (n) begin
            o_op_valid = 1'b0;
            o_ptr_load_en = 1'b0;
            o_source = ~o_source;
            o_instr_step = step;
            @(posedge i_clk_sys);
            #1;
        end
    endtask : idle
endmodule : alt_issue_model
`default_nettype wire

// ---- tb/tb_assoc_lookup_lru_table.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end
module tb_assoc_lookup_lru_table
    import alt_pkg::*;
;
    typedef struct {
        alt_op_t op;
        logic [3:0] ent;
        logic [31:0] src;
        logic [3:0] st;
        logic v;
        logic [31:0] exp;
    } alt_row_t;

    logic i_clk_sys;
    logic i_reset_n;
    logic op_valid;
    logic [2:0] op_code;
    logic [3:0] entry;
    logic [31:0] source;
    logic [3:0] state_imm;
    logic ptr_en;
    logic [1:0] ptr_const;
    logic instr_step;
    logic rv;
    logic [31:0] result;
    logic [11:0] ptr;
    int mismatches = 0;
    int cmp_count = 0;
    alt_row_t rows[$];

    // ------------------------------------------------------------------
    // Clock, parts
    // ------------------------------------------------------------------
    initial begin
        i_clk_sys = 1'b0;
        forever #2 i_clk_sys = ~i_clk_sys;
    end

    alt_issue_model u_model (
        .i_clk_sys(i_clk_sys), .o_op_valid(op_valid),
        .o_op_code(op_code), .o_entry(entry), .o_source(source),
        .o_state_imm(state_imm), .o_ptr_load_en(ptr_en),
        .o_ptr_const(ptr_const), .o_instr_step(instr_step),
        .i_result_valid(rv), .i_result(result)
    );

    alt_lookup_table u_dut (
        .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
        .i_op_valid(op_valid), .i_op_code(op_code), .i_entry(entry),
        .i_source(source), .i_state_imm(state_imm),
        .i_ptr_load_en(ptr_en), .i_ptr_const(ptr_const),
        .i_instr_step(instr_step), .o_result_valid(rv),
        .o_result(result), .o_local_mem_pointer(ptr)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Distinct tag per entry, so no two entries ever share one
    function automatic logic [31:0] tg(input logic [3:0] i);
        return {20'h9C3B0, i, 4'h7, i};
    endfunction : tg

    function automatic logic [3:0] sv(input logic [3:0] i);
        return i ^ 4'hA;
    endfunction : sv

    // Packed lookup word at bits 11:3
    function automatic logic [31:0] res(input logic [3:0] st,
        input logic h, input logic [3:0] idx);
        return {20'h0, st, h, idx, 3'h0};
    endfunction : res

    task automatic add(input alt_op_t op, input logic [3:0] e,
        input logic [31:0] s, input logic [3:0] st, input logic v,
        input logic [31:0] x);
        rows.push_back('{op, e, s, st, v, x});
    endtask : add

    task automatic lk(input logic [31:0] s, input logic [31:0] x);
        add(ALT_OP_LOOKUP, 4'h0, s, 4'h0, 1'b1, x);
    endtask : lk

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude

    // Watchdog: whole run is about 116 cycles, limit 3000 cycles
    initial begin
        #(4 * 3000);
        mismatches++;
        conclude();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic v;
        logic [31:0] r;
        logic [3:0] e;
        alt_row_t w;
        i_reset_n = 1'b0;
        repeat (16) @(posedge i_clk_sys);
        #1;
        i_reset_n = 1'b1;
        // Table rows, issued back to back
        add(ALT_OP_CLEAR, 4'h0, 32'h0, 4'h0, 1'b0, 32'h0);
        add(ALT_OP_RD_TAG, 4'hF, 32'h0, 4'h0, 1'b1, ALT_CLEAR_TAG);
        add(ALT_OP_RD_STATE, 4'h3, 32'h0, 4'h0, 1'b1, 32'h0);
        lk(32'h1, res(4'h0, 1'b0, 4'h0));
        for (int k = 0; k < 16; k++) begin
            e = 4'(k) ^ 4'h5;
            add(ALT_OP_LOAD, e, tg(e), sv(e), 1'b0, 32'h0);
        end
        for (int k = 0; k < 16; k++) begin
            e = 4'(k);
            add(ALT_OP_RD_TAG, e, 32'h0, 4'h0, 1'b1, tg(e));
            add(ALT_OP_RD_STATE, e, 32'h0, 4'h0, 1'b1,
                {20'h0, sv(e), 8'h0});
        end
        add(ALT_OP_NONE, 4'h0, 32'h0, 4'h0, 1'b0, 32'h0);
        lk(32'hFFFF_FFFF, res(4'h0, 1'b0, 4'h5));
        lk(32'hFFFF_FFFF, res(4'h0, 1'b0, 4'h5));
        lk(tg(4'h5), res(sv(4'h5), 1'b1, 4'h5));
        lk(32'hFFFF_FFFF, res(4'h0, 1'b0, 4'h4));
        add(ALT_OP_WR_STATE, 4'h4, 32'h0, 4'h3, 1'b0, 32'h0);
        lk(32'hFFFF_FFFF, res(4'h0, 1'b0, 4'h4));
        add(ALT_OP_RD_TAG, 4'h4, 32'h0, 4'h0, 1'b1, tg(4'h4));
        lk(tg(4'h4), res(4'h3, 1'b1, 4'h4));
        add(ALT_OP_RD_TAG, 4'h7, 32'h0, 4'h0, 1'b1, tg(4'h7));
        lk(32'hFFFF_FFFF, res(4'h0, 1'b0, 4'h7));
        lk(tg(4'h3) ^ 32'h8000_0000, res(4'h0, 1'b0, 4'h7));
        lk(tg(4'h3) ^ 32'h0000_0001, res(4'h0, 1'b0, 4'h7));
        add(ALT_OP_LOAD, 4'h7, 32'h0, 4'h6, 1'b0, 32'h0);
        add(ALT_OP_RD_TAG, 4'h7, 32'h0, 4'h0, 1'b1, 32'h0);
        lk(32'h0, res(4'h6, 1'b1, 4'h7));
        lk(32'hFFFF_FFFF, res(4'h0, 1'b0, 4'h6));
        lk(tg(4'h7), res(4'h0, 1'b0, 4'h6));
        foreach (rows[i]) begin
            w = rows[i];
            u_model.issue(w.op, w.ent, w.src, w.st, 1'b0, 2'h0, v, r);
            `CHK(v, w.v)
            if (w.v) `CHK(r, w.exp)
        end
        // Pointer load counts retired instructions, not cycles
        u_model.issue(ALT_OP_LOOKUP, 4'h0, tg(4'h9), 4'h0, 1'b1, 2'h2,
            v, r);
        `CHK(r, res(sv(4'h9), 1'b1, 4'h9))
        u_model.idle(4, 1'b0);
        `CHK(rv, 1'b0)
        `CHK(ptr, ALT_PTR_RESET)
        u_model.idle(1, 1'b1);
        `CHK(ptr, ALT_PTR_RESET)
        u_model.idle(5, 1'b1);
        `CHK(ptr, {2'h2, 4'h9, 6'h0})
        // Miss loads the replacement candidate into the pointer
        u_model.issue(ALT_OP_LOOKUP, 4'h0, 32'h5, 4'h0, 1'b1, 2'h1, v, r);
        u_model.idle(6, 1'b1);
        `CHK(ptr, {2'h1, 4'h6, 6'h0})
        // Engine reset must leave contents and ordering alone
        i_reset_n = 1'b0;
        u_model.idle(3, 1'b1);
        `CHK(ptr, ALT_PTR_RESET)
        i_reset_n = 1'b1;
        u_model.issue(ALT_OP_LOOKUP, 4'h0, tg(4'h2), 4'h0, 1'b0, 2'h0,
            v, r);
        `CHK(r, res(sv(4'h2), 1'b1, 4'h2))
        u_model.issue(ALT_OP_LOOKUP, 4'h0, 32'h5, 4'h0, 1'b0, 2'h0, v, r);
        `CHK(r, res(4'h0, 1'b0, 4'h6))
        // Clear mid-run restores entry 0 as the oldest
        u_model.issue(ALT_OP_CLEAR, 4'h0, 32'h0, 4'h0, 1'b0, 2'h0, v, r);
        u_model.issue(ALT_OP_LOOKUP, 4'h0, 32'h5, 4'h0, 1'b0, 2'h0, v, r);
        `CHK(r, res(4'h0, 1'b0, 4'h0))
        u_model.issue(ALT_OP_RD_STATE, 4'h9, 32'h0, 4'h0, 1'b0, 2'h0,
            v, r);
        `CHK(r, 32'h0)
        u_model.issue(ALT_OP_LOAD, 4'h0, 32'h55, 4'h1, 1'b0, 2'h0, v, r);
        u_model.issue(ALT_OP_LOOKUP, 4'h0, 32'h5, 4'h0, 1'b0, 2'h0, v, r);
        `CHK(r, res(4'h0, 1'b0, 4'h1))
        u_model.idle(2, 1'b1);
        conclude();
    end
endmodule : tb_assoc_lookup_lru_table
`default_nettype wire
